// >>> sbda_map.vh
// constants for the serial boot download engine
// assumes inclusion by bare name from the loader source
`ifndef SBDA_MAP_VH
`define SBDA_MAP_VH
// frame identifiers, host to device and echo
`define SBDA_ID_PWD_RX 11'h011
`define SBDA_ID_HDR_RX 11'h012
`define SBDA_ID_DAT_RX 11'h013
`define SBDA_ID_PWD_TX 11'h001
`define SBDA_ID_HDR_TX 11'h002
`define SBDA_ID_DAT_TX 11'h003
`define SBDA_CAN_MAX_BYTES 4'h8
// protocol field sizes
`define SBDA_PWD_LAST 4'h7
`define SBDA_HDR_LAST 4'h7
`define SBDA_FLAG_BIT 31
`define SBDA_ACK_BYTE 8'h59
// uart timing: zero byte is 9 low bits, 16 samples per bit
`define SBDA_BAUD_DIVISOR 24'h90
`define SBDA_OVS_SHIFT 4'h0
`define SBDA_DIV_MAX 13'h1fff
`define SBDA_DIV_MIN 13'h001
`define SBDA_FIXED_BIT_CYC 17'h00341
`define SBDA_UART_FRAME_BITS 4'ha
`define SBDA_UART_DATA_LAST 4'h7
// oscillator bands in MHz and pll multipliers
`define SBDA_OSC_12 6'h0c
`define SBDA_OSC_16 6'h10
`define SBDA_OSC_24 6'h18
`define SBDA_MULT_X4 3'h4
`define SBDA_MULT_X3 3'h3
`define SBDA_MULT_X2 3'h2
`define SBDA_MULT_X1 3'h1
`endif

// >>> sbda_fifo.v
// byte fifo between the protocol engine and the sram word packer
// assumes one clock, synchronous active-high reset, clock enable
`timescale 1ns/1ps
`default_nettype none
module sbda_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    localparam [AW:0] FULL = DEPTH;
    localparam [AW:0] ONE = 1;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    reg ov_q;
    reg [WIDTH-1:0] od_q;
    wire push;
    wire load;

    // head word sits in a register so the reader sees flopped data
    assign o_in_ready = (cnt_q != FULL);
    assign push = i_in_valid && o_in_ready;
    assign load = (cnt_q != {(AW+1){1'b0}}) && (!ov_q || i_out_ready);
    assign o_out_valid = ov_q;
    assign o_out_data = od_q;

    // storage array, no reset needed
    always @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[wp_q] <= i_in_data;
        end
    end

    // pointers, occupancy and output stage
    always @(posedge i_clk) begin
        if (i_rst) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            ov_q <= 1'b0;
            od_q <= {WIDTH{1'b0}};
        end else if (i_ce) begin
            if (push) begin
                wp_q <= wp_q + ONE[AW-1:0];
            end
            if (load) begin
                od_q <= mem[rp_q];
                rp_q <= rp_q + ONE[AW-1:0];
                ov_q <= 1'b1;
            end else if (ov_q && i_out_ready) begin
                ov_q <= 1'b0;
            end
            if (push && !load) begin
                cnt_q <= cnt_q + ONE;
            end else if (load && !push) begin
                cnt_q <= cnt_q - ONE;
            end
        end
    end
endmodule
`default_nettype wire

// >>> sbda_loader.v
// serial boot download engine: can or uart image load into sram
// assumes frame-level can controller ports, uart pin synchronous to clock
`timescale 1ns/1ps
`default_nettype none
`include "sbda_map.vh"
module sbda_loader (
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire I_CE,
    input wire I_MODE_CAN,
    input wire I_AUTOBAUD,
    input wire [63:0] I_STORED_PWD,
    output reg O_CLKMON_START,
    input wire I_CLKMON_DONE,
    input wire [5:0] I_OSC_MHZ,
    output reg [2:0] O_PLL_MULT,
    output reg O_PLL_LOAD,
    input wire I_PLL_LOCK,
    input wire I_UART_RX,
    output reg O_UART_TX,
    output reg [12:0] O_BAUD_DIV,
    input wire I_CAN_RX_VALID,
    output reg O_CAN_RX_READY,
    input wire [10:0] I_CAN_RX_ID,
    input wire [3:0] I_CAN_RX_DLC,
    input wire [63:0] I_CAN_RX_DATA,
    output reg O_CAN_TX_VALID,
    input wire I_CAN_TX_READY,
    output reg [10:0] O_CAN_TX_ID,
    output reg [3:0] O_CAN_TX_DLC,
    output reg [63:0] O_CAN_TX_DATA,
    output reg O_MEM_WE,
    input wire I_MEM_READY,
    output reg [31:0] O_MEM_ADDR,
    output reg [31:0] O_MEM_WDATA,
    output reg O_FAIL,
    output reg O_BRANCH,
    output reg [31:0] O_BRANCH_ADDR
);
    localparam S_INIT = 4'h0, S_CLKMON = 4'h1, S_PLL = 4'h2, S_WFALL = 4'h3;
    localparam S_WRISE = 4'h4, S_ACK = 4'h5, S_PWD = 4'h6, S_HDR = 4'h7;
    localparam S_DATA = 4'h8, S_FLUSH = 4'h9, S_DONE = 4'ha, S_FAIL = 4'hb;

    // pll band selection keeps system clock just under its ceiling
    function [2:0] pll_mult;
        input [5:0] mhz;
        begin
            if (mhz < `SBDA_OSC_12) begin
                pll_mult = `SBDA_MULT_X4;
            end else if (mhz < `SBDA_OSC_16) begin
                pll_mult = `SBDA_MULT_X3;
            end else if (mhz < `SBDA_OSC_24) begin
                pll_mult = `SBDA_MULT_X2;
            end else begin
                pll_mult = `SBDA_MULT_X1;
            end
        end
    endfunction

    // integer divider from zero-byte width, clamped to the 13-bit field
    function [12:0] baud_div;
        input [23:0] tb;
        reg [23:0] q;
        begin
            q = tb / `SBDA_BAUD_DIVISOR;
            if (q > {11'h000, `SBDA_DIV_MAX}) begin
                baud_div = `SBDA_DIV_MAX;
            end else if (q == 24'h000000) begin
                baud_div = `SBDA_DIV_MIN;
            end else begin
                baud_div = q[12:0];
            end
        end
    endfunction

    reg [3:0] state_q;
    reg [3:0] cnt_q;
    reg [63:0] sh_q;
    reg [31:0] addr_q;
    reg [30:0] len_q;
    reg [30:0] rcv_q;
    reg [30:0] wr_q;
    reg [23:0] tmr_q;
    reg [16:0] bitcyc_q;
    reg line_q;
    reg [63:0] frm_q;
    reg [3:0] unp_q;
    reg rx_act_q;
    reg [17:0] rx_cyc_q;
    reg [3:0] rx_bit_q;
    reg [7:0] rx_sh_q;
    reg rx_done_q;
    reg tx_act_q;
    reg [16:0] tx_cyc_q;
    reg [3:0] tx_bit_q;
    reg [9:0] tx_sh_q;
    reg tx_pend_q;
    reg [7:0] tx_hold_q;
    reg [31:0] acc_q;
    reg [1:0] lane_q;
    reg [12:0] div_n;
    reg [10:0] exp_id;
    reg [10:0] echo_id;

    wire in_proto = (state_q == S_PWD) || (state_q == S_HDR) || (state_q == S_DATA);
    wire byte_v = I_MODE_CAN ? (unp_q != 4'h0) : rx_done_q;
    wire [7:0] byte_d = I_MODE_CAN ? frm_q[63:56] : rx_sh_q;
    wire f_in_ready;
    wire f_out_valid;
    wire [7:0] f_out_data;
    wire take = in_proto && byte_v && ((state_q != S_DATA) || f_in_ready);
    wire push = take && (state_q == S_DATA);
    wire pop = f_out_valid && !O_MEM_WE;
    wire can_acc = I_CAN_RX_VALID && O_CAN_RX_READY;
    wire [63:0] sh_n = {sh_q[55:0], byte_d};
    wire last_byte = ((wr_q + 31'h1) == len_q);
    wire [4:0] pad_sh = {(2'h3 - lane_q), 3'h0};
    wire [31:0] word_n = {acc_q[23:0], f_out_data} << pad_sh;

    // step-dependent identifiers, 11-bit standard format
    always @* begin
        case (state_q)
            S_PWD: begin
                exp_id = `SBDA_ID_PWD_RX;
                echo_id = `SBDA_ID_PWD_TX;
            end
            S_HDR: begin
                exp_id = `SBDA_ID_HDR_RX;
                echo_id = `SBDA_ID_HDR_TX;
            end
            default: begin
                exp_id = `SBDA_ID_DAT_RX;
                echo_id = `SBDA_ID_DAT_TX;
            end
        endcase
        div_n = baud_div(tmr_q);
    end

    sbda_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_fifo (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_in_valid(push),
        .o_in_ready(f_in_ready),
        .i_in_data(byte_d),
        .o_out_valid(f_out_valid),
        .i_out_ready(!O_MEM_WE),
        .o_out_data(f_out_data)
    );

    // main sequencer: clock setup, autobaud, protocol, packing
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            state_q <= S_INIT;
            cnt_q <= 4'h0;
            sh_q <= 64'h0;
            addr_q <= 32'h0;
            len_q <= 31'h0;
            rcv_q <= 31'h0;
            wr_q <= 31'h0;
            tmr_q <= 24'h0;
            bitcyc_q <= `SBDA_FIXED_BIT_CYC;
            line_q <= 1'b1;
            frm_q <= 64'h0;
            unp_q <= 4'h0;
            rx_act_q <= 1'b0;
            rx_cyc_q <= 18'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h0;
            rx_done_q <= 1'b0;
            tx_act_q <= 1'b0;
            tx_cyc_q <= 17'h0;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 10'h3ff;
            tx_pend_q <= 1'b0;
            tx_hold_q <= 8'h0;
            acc_q <= 32'h0;
            lane_q <= 2'h0;
            O_CLKMON_START <= 1'b0;
            O_PLL_MULT <= `SBDA_MULT_X1;
            O_PLL_LOAD <= 1'b0;
            O_UART_TX <= 1'b1;
            O_BAUD_DIV <= 13'h0;
            O_CAN_RX_READY <= 1'b0;
            O_CAN_TX_VALID <= 1'b0;
            O_CAN_TX_ID <= 11'h0;
            O_CAN_TX_DLC <= 4'h0;
            O_CAN_TX_DATA <= 64'h0;
            O_MEM_WE <= 1'b0;
            O_MEM_ADDR <= 32'h0;
            O_MEM_WDATA <= 32'h0;
            O_FAIL <= 1'b0;
            O_BRANCH <= 1'b0;
            O_BRANCH_ADDR <= 32'h0;
        end else if (I_CE) begin
            O_CLKMON_START <= 1'b0;
            O_PLL_LOAD <= 1'b0;
            O_BRANCH <= 1'b0;
            rx_done_q <= 1'b0;
            line_q <= I_UART_RX;

            // uart receiver, sampled mid-bit, lsb first
            if (!I_MODE_CAN && in_proto && !rx_act_q && line_q && !I_UART_RX) begin
                rx_act_q <= 1'b1;
                rx_bit_q <= 4'h0;
                rx_cyc_q <= {1'b0, bitcyc_q} + {2'b00, bitcyc_q[16:1]};
            end else if (rx_act_q) begin
                if (rx_cyc_q == 18'h1) begin
                    rx_sh_q <= {I_UART_RX, rx_sh_q[7:1]};
                    rx_cyc_q <= {1'b0, bitcyc_q};
                    rx_bit_q <= rx_bit_q + 4'h1;
                    if (rx_bit_q == `SBDA_UART_DATA_LAST) begin
                        rx_act_q <= 1'b0;
                        rx_done_q <= 1'b1;
                    end
                end else begin
                    rx_cyc_q <= rx_cyc_q - 18'h1;
                end
            end

            // uart transmitter with one byte of holding
            if (!tx_act_q && tx_pend_q) begin
                tx_act_q <= 1'b1;
                tx_pend_q <= 1'b0;
                tx_sh_q <= {1'b1, tx_hold_q, 1'b0};
                tx_bit_q <= `SBDA_UART_FRAME_BITS;
                tx_cyc_q <= 17'h1;
            end else if (tx_act_q) begin
                if (tx_cyc_q == 17'h1) begin
                    if (tx_bit_q == 4'h0) begin
                        tx_act_q <= 1'b0;
                    end else begin
                        O_UART_TX <= tx_sh_q[0];
                        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                        tx_bit_q <= tx_bit_q - 4'h1;
                        tx_cyc_q <= bitcyc_q;
                    end
                end else begin
                    tx_cyc_q <= tx_cyc_q - 17'h1;
                end
            end
            if (take && !I_MODE_CAN) begin
                tx_pend_q <= 1'b1; // echo every uart byte
                tx_hold_q <= byte_d;
            end

            // can frame intake; ready comes back once a frame is unpacked and its echo taken
            if (can_acc) begin
                O_CAN_RX_READY <= 1'b0;
                if (I_CAN_RX_ID == exp_id) begin
                    frm_q <= I_CAN_RX_DATA;
                    unp_q <= (I_CAN_RX_DLC > `SBDA_CAN_MAX_BYTES) ?
                        `SBDA_CAN_MAX_BYTES : I_CAN_RX_DLC;
                    O_CAN_TX_VALID <= 1'b1;
                    O_CAN_TX_ID <= echo_id;
                    O_CAN_TX_DLC <= I_CAN_RX_DLC;
                    O_CAN_TX_DATA <= I_CAN_RX_DATA;
                end
            end else begin
                O_CAN_RX_READY <= I_MODE_CAN && in_proto && (unp_q == 4'h0) &&
                    !O_CAN_TX_VALID;
                if (O_CAN_TX_VALID && I_CAN_TX_READY) begin
                    O_CAN_TX_VALID <= 1'b0;
                end
                if (!in_proto) begin
                    unp_q <= 4'h0; // surplus bytes of the final frame dropped
                end else if (take && I_MODE_CAN) begin
                    frm_q <= {frm_q[55:0], 8'h00};
                    unp_q <= unp_q - 4'h1;
                end
            end

            // word packer drains the fifo into sram
            if (O_MEM_WE && I_MEM_READY) begin
                O_MEM_WE <= 1'b0;
            end
            if (pop) begin
                wr_q <= wr_q + 31'h1;
                if ((lane_q == 2'h3) || last_byte) begin
                    O_MEM_WE <= 1'b1;
                    O_MEM_ADDR <= addr_q;
                    O_MEM_WDATA <= word_n;
                    addr_q <= addr_q + 32'h4;
                    acc_q <= 32'h0;
                    lane_q <= 2'h0;
                end else begin
                    acc_q <= {acc_q[23:0], f_out_data};
                    lane_q <= lane_q + 2'h1;
                end
            end

            // protocol and setup sequence
            case (state_q)
                S_INIT: begin
                    if (!I_MODE_CAN && I_AUTOBAUD) begin
                        O_CLKMON_START <= 1'b1;
                        state_q <= S_CLKMON;
                    end else begin
                        state_q <= S_PWD;
                    end
                end
                S_CLKMON: begin
                    if (I_CLKMON_DONE) begin
                        O_PLL_MULT <= pll_mult(I_OSC_MHZ);
                        O_PLL_LOAD <= 1'b1;
                        state_q <= S_PLL;
                    end
                end
                S_PLL: begin
                    if (I_PLL_LOCK) begin
                        state_q <= S_WFALL;
                    end
                end
                S_WFALL: begin
                    if (line_q && !I_UART_RX) begin
                        tmr_q <= 24'h1;
                        state_q <= S_WRISE;
                    end
                end
                S_WRISE: begin
                    if (I_UART_RX) begin
                        O_BAUD_DIV <= div_n;
                        bitcyc_q <= {div_n, `SBDA_OVS_SHIFT};
                        tx_pend_q <= 1'b1;
                        tx_hold_q <= `SBDA_ACK_BYTE;
                        state_q <= S_ACK;
                    end else begin
                        tmr_q <= tmr_q + 24'h1;
                    end
                end
                S_ACK: begin
                    if (!tx_pend_q && !tx_act_q) begin
                        state_q <= S_PWD;
                    end
                end
                S_PWD: begin
                    if (take) begin
                        sh_q <= sh_n;
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == `SBDA_PWD_LAST) begin
                            cnt_q <= 4'h0;
                            state_q <= (sh_n == I_STORED_PWD) ? S_HDR : S_FAIL;
                        end
                    end
                end
                S_HDR: begin
                    if (take) begin
                        sh_q <= sh_n;
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == `SBDA_HDR_LAST) begin
                            cnt_q <= 4'h0;
                            addr_q <= {sh_n[63:34], 2'b00};
                            O_BRANCH_ADDR <= {sh_n[63:34], 2'b00};
                            len_q <= sh_n[30:0];
                            rcv_q <= 31'h0;
                            if (!sh_n[`SBDA_FLAG_BIT]) begin
                                state_q <= S_FAIL;
                            end else if (sh_n[30:0] == 31'h0) begin
                                state_q <= S_FLUSH;
                            end else begin
                                state_q <= S_DATA;
                            end
                        end
                    end
                end
                S_DATA: begin
                    if (push) begin
                        rcv_q <= rcv_q + 31'h1;
                        if ((rcv_q + 31'h1) == len_q) begin
                            state_q <= S_FLUSH;
                        end
                    end
                end
                S_FLUSH: begin
                    // last echo and last word must be out before the branch
                    if ((wr_q == len_q) && !O_MEM_WE && !O_CAN_TX_VALID &&
                        !tx_act_q && !tx_pend_q) begin
                        O_BRANCH <= 1'b1;
                        state_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    state_q <= S_DONE;
                end
                S_FAIL: begin
                    O_FAIL <= 1'b1;
                end
                default: begin
                    state_q <= S_FAIL;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> sbda_assertions.sv
// port-level checker for the serial boot loader
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sbda_assertions (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_CLKMON_DONE,
    input wire logic [5:0] I_OSC_MHZ,
    input wire logic [2:0] O_PLL_MULT,
    input wire logic O_PLL_LOAD,
    input wire logic I_CAN_RX_VALID,
    input wire logic O_CAN_RX_READY,
    input wire logic [10:0] I_CAN_RX_ID,
    input wire logic [3:0] I_CAN_RX_DLC,
    input wire logic [63:0] I_CAN_RX_DATA,
    input wire logic O_CAN_TX_VALID,
    input wire logic I_CAN_TX_READY,
    input wire logic [10:0] O_CAN_TX_ID,
    input wire logic [3:0] O_CAN_TX_DLC,
    input wire logic [63:0] O_CAN_TX_DATA,
    input wire logic O_MEM_WE,
    input wire logic I_MEM_READY,
    input wire logic [31:0] O_MEM_ADDR,
    input wire logic [31:0] O_MEM_WDATA,
    input wire logic O_FAIL,
    input wire logic O_BRANCH,
    input wire logic [31:0] O_BRANCH_ADDR
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    logic [5:0] osc_q;
    logic [31:0] waddr_q;
    logic wseen_q;
    wire take = I_CAN_RX_VALID && O_CAN_RX_READY;
    wire id_ok = (I_CAN_RX_ID >= 11'h011) && (I_CAN_RX_ID <= 11'h013);
    // expected multiplier per crystal band
    function automatic logic [2:0] mult_for(input logic [5:0] m);
        if (m < 6'h0c) return 3'h4;
        if (m < 6'h10) return 3'h3;
        if (m < 6'h18) return 3'h2;
        return 3'h1;
    endfunction
    // last measured crystal and last accepted write address
    always @(posedge I_CLK_SYS) begin
        if (I_CLKMON_DONE) osc_q <= I_OSC_MHZ;
        if (I_RST) wseen_q <= 1'b0;
        else if (O_MEM_WE && I_MEM_READY) begin
            wseen_q <= 1'b1;
            waddr_q <= O_MEM_ADDR;
        end
    end
    chk_echo_copy: assert property ($rose(O_CAN_TX_VALID) |-> $past(take) &&
        O_CAN_TX_ID == $past(I_CAN_RX_ID) - 11'h010 && O_CAN_TX_DLC == $past(I_CAN_RX_DLC)
        && O_CAN_TX_DATA == $past(I_CAN_RX_DATA)) else $error("echo differs from frame");
    chk_wrong_id_quiet: assert property (take && !id_ok |=> !O_CAN_TX_VALID)
        else $error("frame with foreign id echoed");
    chk_echo_holds: assert property (O_CAN_TX_VALID && !I_CAN_TX_READY |=> O_CAN_TX_VALID
        && $stable(O_CAN_TX_ID) && $stable(O_CAN_TX_DATA)) else $error("echo dropped early");
    chk_ready_drops: assert property (take |=> !O_CAN_RX_READY)
        else $error("ready stayed high after take");
    chk_write_holds: assert property (O_MEM_WE && !I_MEM_READY |=> O_MEM_WE
        && $stable(O_MEM_ADDR) && $stable(O_MEM_WDATA)) else $error("write dropped early");
    chk_addr_step: assert property ($rose(O_MEM_WE) && wseen_q |->
        O_MEM_ADDR == waddr_q + 32'h4) else $error("write address not next word");
    chk_branch_quiet: assert property (O_BRANCH |-> O_BRANCH_ADDR[1:0] == 2'h0 ##1
        (!O_BRANCH && !O_CAN_TX_VALID && !O_MEM_WE) [*8]) else $error("activity after branch");
    chk_pll_band: assert property (O_PLL_LOAD |=> O_PLL_MULT == mult_for(osc_q))
        else $error("pll multiplier wrong for band");
    chk_fail_sticky: assert property (O_FAIL |=> O_FAIL)
        else $error("fail flag cleared");
endmodule
`default_nettype wire

// >>> sbda_host.sv
// boot host model on the can side of the loader
// assumes tasks are called from the bench just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module sbda_host (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_rx_ready,
    output var logic o_rx_valid,
    output var logic [10:0] o_rx_id,
    output var logic [3:0] o_rx_dlc,
    output var logic [63:0] o_rx_data,
    output var logic o_tx_ready
);
    logic [2:0] tick_q = 3'h0;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_id = 11'h7ff;
        o_rx_dlc = 4'h0;
        o_rx_data = 64'h0;
        o_tx_ready = 1'b0;
    end
    // slow host takes an echo only one cycle in eight
    always @(posedge i_clk) begin
        tick_q <= tick_q + 3'h1;
        o_tx_ready <= !i_slow || (tick_q == 3'h7);
    end
    // frame held until taken; id and data scrambled after so stale data never passes
    task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
        o_rx_valid = 1'b1;
        o_rx_id = id;
        o_rx_dlc = dlc;
        o_rx_data = data;
        while (i_rx_ready !== 1'b1) begin
            @(posedge i_clk);
            #1;
        end
        @(posedge i_clk);
        #1;
        o_rx_valid = 1'b0;
        o_rx_id = ~id;
        o_rx_data = ~data;
        // one idle edge so back-to-back frames never retoggle valid in one step
        @(posedge i_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> sbda_loader_tb.sv
// self-checking bench for the boot loader: can download and uart autobaud
// assumes sbda_host and sbda_assertions are compiled first
`timescale 1ns/1ps
`default_nettype none
module sbda_loader_tb;
    localparam logic [63:0] PWD = 64'h0123_4567_89ab_cdef;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mode_can = 1'b1;
    logic autob = 1'b0;
    logic cm_done = 1'b0;
    logic [5:0] osc = 6'h00;
    logic lock = 1'b0;
    logic urx = 1'b1;
    logic mem_rdy = 1'b0;
    logic slow = 1'b0;
    wire rx_valid, rx_ready, tx_valid, tx_ready, cm_start, pll_load, utx, we, fail, br;
    wire [10:0] rx_id, tx_id;
    wire [3:0] rx_dlc, tx_dlc;
    wire [63:0] rx_data, tx_data;
    wire [2:0] mult;
    wire [12:0] bdiv;
    wire [31:0] maddr, mdata, br_addr;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int echoes = 0;
    logic [31:0] wa[$];
    logic [31:0] wd[$];
    logic [31:0] bra = 32'h0;

    sbda_loader dut (.I_CLK_SYS(clk), .I_RST(rst), .I_CE(1'b1), .I_MODE_CAN(mode_can),
        .I_AUTOBAUD(autob), .I_STORED_PWD(PWD), .O_CLKMON_START(cm_start),
        .I_CLKMON_DONE(cm_done), .I_OSC_MHZ(osc), .O_PLL_MULT(mult), .O_PLL_LOAD(pll_load),
        .I_PLL_LOCK(lock), .I_UART_RX(urx), .O_UART_TX(utx), .O_BAUD_DIV(bdiv),
        .I_CAN_RX_VALID(rx_valid), .O_CAN_RX_READY(rx_ready), .I_CAN_RX_ID(rx_id),
        .I_CAN_RX_DLC(rx_dlc), .I_CAN_RX_DATA(rx_data), .O_CAN_TX_VALID(tx_valid),
        .I_CAN_TX_READY(tx_ready), .O_CAN_TX_ID(tx_id), .O_CAN_TX_DLC(tx_dlc),
        .O_CAN_TX_DATA(tx_data), .O_MEM_WE(we), .I_MEM_READY(mem_rdy), .O_MEM_ADDR(maddr),
        .O_MEM_WDATA(mdata), .O_FAIL(fail), .O_BRANCH(br), .O_BRANCH_ADDR(br_addr));
    sbda_host host (.i_clk(clk), .i_slow(slow), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
        .o_rx_id(rx_id), .o_rx_dlc(rx_dlc), .o_rx_data(rx_data), .o_tx_ready(tx_ready));

    always #4 clk = ~clk;
    // sram stalls every other cycle; echoes and writes logged as accepted
    always @(posedge clk) begin
        mem_rdy <= ~mem_rdy;
        cycles <= cycles + 1;
        if (!rst && tx_valid && tx_ready) echoes <= echoes + 1;
        if (!rst && we && mem_rdy) begin
            wa.push_back(maddr);
            wd.push_back(mdata);
        end
        if (!rst && br) bra <= br_addr;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end

    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // mode pins change only under reset
    task automatic boot(input logic can, input logic ab);
        rst = 1'b1;
        mode_can = can;
        autob = ab;
        lock = 1'b0;
        wa.delete();
        wd.delete();
        echoes = 0;
        bra = 32'h0;
        repeat (10) step();
        rst = 1'b0;
    endtask
    // two stray frames first, slow echo taker, image spread over two frames
    task automatic can_good;
        boot(1'b1, 1'b0);
        slow = 1'b1;
        host.send(11'h013, 4'h2, 64'hdead_0000_0000_0000);
        host.send(11'h014, 4'h1, 64'h0);
        host.send(11'h011, 4'h8, PWD);
        host.send(11'h012, 4'h8, {32'h2000_0100, 1'b1, 31'h6});
        host.send(11'h013, 4'h5, 64'h1122_3344_5500_0000);
        host.send(11'h013, 4'h1, 64'h6600_0000_0000_0000);
        for (int i = 0; i < 400 && br !== 1'b1; i++) step();
        step();
        chk("echo count", 64'h4, 64'(echoes));
        chk("write count", 64'h2, 64'(wa.size()));
        chk("word 0", 64'h2000_0100_1122_3344, {wa[0], wd[0]});
        chk("word 1", 64'h2000_0104_5566_0000, {wa[1], wd[1]});
        chk("branch addr", 64'h2000_0100, {32'h0, bra});
        chk("fail", 64'h0, {63'h0, fail});
    endtask
    // wrong password, or right password with the flag cleared
    task automatic can_fail(input logic [63:0] pwd, input logic flag);
        boot(1'b1, 1'b0);
        slow = 1'b0;
        host.send(11'h011, 4'h8, pwd);
        if (pwd === PWD) host.send(11'h012, 4'h8, {32'h2000_0000, flag, 31'h4});
        for (int i = 0; i < 100 && fail !== 1'b1; i++) step();
        chk("fail flag", 64'h1, {63'h0, fail});
        chk("no write", 64'h0, 64'(wa.size()));
    endtask
    // one 8n1 frame from the host at 48 cycles a bit, lsb first
    task automatic ubyte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            urx = f[i];
            repeat (48) step();
        end
    endtask
    // every crystal band, zero byte held low 452 cycles, then a zero-length download
    task automatic uart_auto;
        logic [5:0] oscs[5] = '{6'h06, 6'h0a, 6'h0e, 6'h14, 6'h1a};
        logic [2:0] mults[5] = '{3'h4, 3'h4, 3'h3, 3'h2, 3'h1};
        logic [127:0] msg = {PWD, 64'h2000_0200_8000_0000};
        logic [7:0] b;
        for (int k = 0; k < 5; k++) begin
            boot(1'b0, 1'b1);
            for (int i = 0; i < 20 && cm_start !== 1'b1; i++) step();
            step();
            osc = oscs[k];
            cm_done = 1'b1;
            step();
            cm_done = 1'b0;
            for (int i = 0; i < 50 && pll_load !== 1'b1; i++) step();
            step();
            chk("pll mult", 64'(mults[k]), 64'(mult));
        end
        lock = 1'b1;
        repeat (10) step();
        urx = 1'b0;
        repeat (452) step();
        urx = 1'b1;
        for (int i = 0; i < 200 && utx !== 1'b0; i++) step();
        chk("baud div", 64'h3, 64'(bdiv));
        repeat (24) step();
        chk("ack start", 64'h0, 64'(utx));
        for (int i = 0; i < 8; i++) begin
            repeat (48) step();
            b[i] = utx;
        end
        repeat (48) step();
        chk("ack byte", 64'h59, 64'(b));
        chk("ack stop", 64'h1, 64'(utx));
        repeat (48) step();
        for (int i = 15; i >= 0; i--) ubyte(msg[8*i +: 8]);
        for (int i = 0; i < 1000 && br !== 1'b1; i++) step();
        step();
        chk("uart branch", 64'h2000_0200, {32'h0, bra});
        chk("uart fail", 64'h0, {63'h0, fail});
    endtask

    initial begin
        can_good();
        can_fail(PWD ^ 64'h1, 1'b1);
        can_fail(PWD, 1'b0);
        uart_auto();
        give_verdict();
    end
endmodule
bind sbda_loader sbda_assertions chk_u (.*);
`default_nettype wire
